/* File: src/dio_map.vh */
// register map, field codes and timing constants of the digital i/o block
// assumes a word-addressed avalon-mm slave, byte address = word index * 4
`ifndef DIO_MAP_VH
`define DIO_MAP_VH

// ****************************************
// register word indices
// ****************************************
`define DIO_REG_INVERT 4'h0
`define DIO_REG_FUNC 4'h1
`define DIO_REG_GPO 4'h2
`define DIO_REG_GPI 4'h3
`define DIO_REG_TRIG_EN 4'h4
`define DIO_REG_PULSE_W 4'h5
`define DIO_REG_IRQ_STAT 4'h6
`define DIO_REG_IRQ_MASK 4'h7
`define DIO_REG_CTRL 4'h8

// ****************************************
// reset values
// ****************************************
`define DIO_RST_INVERT 7'h00
`define DIO_RST_FUNC 14'h2aaa
`define DIO_RST_GPO 7'h00
`define DIO_RST_TRIG_EN 8'h00
`define DIO_RST_PULSE_W 9'h01e
`define DIO_RST_IRQ_MASK 6'h00

// ****************************************
// two-bit function codes per pin
// ****************************************
`define DIO_FN_SPEC_A 2'h0
`define DIO_FN_SPEC_B 2'h1
`define DIO_FN_INPUT 2'h2
`define DIO_FN_OUTPUT 2'h3

// ****************************************
// interrupt status bits
// ****************************************
`define DIO_IRQ_INHIBIT 0
`define DIO_IRQ_PCLEAR 1
`define DIO_IRQ_TRIG1_IN 2
`define DIO_IRQ_SECOND_EVENT_PIN_IN 3
`define DIO_IRQ_PULSE1 4
`define DIO_IRQ_PULSE2 5

// ctrl write bit: clear latched inhibit
`define DIO_CTRL_INH_CLR 0

// ****************************************
// timing
// ****************************************
`define DIO_CLK_HZ 20000000
`define DIO_CYC_PER_US (`DIO_CLK_HZ / 1000000)
`define DIO_PW_MIN_US 9'd30
`define DIO_PW_MAX_US 9'd500

`endif

/* File: src/dio_pins.v */
// seven-pin configurable rear-panel digital i/o with trigger pulse outputs
// assumes pin inputs and instrument event strobes are synchronous to mclk
`include "dio_map.vh"
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// trigger pulse timer
// ****************************************
module dio_pulse (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // control
  input wire fire,
  input wire [15:0] width_cyc,
  // state
  output reg active_q
);
  reg [15:0] cnt_q;

  // a fire during an active pulse is ignored, pulses never stretch
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      active_q <= 1'b0;
    end else if (!active_q && fire) begin
      cnt_q <= width_cyc - 16'h0001;
      active_q <= 1'b1;
    end else if (active_q) begin
      if (cnt_q == 16'h0000) begin
        active_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule

// ****************************************
// top
// ****************************************
module dio_pins #(
  parameter CYC_PER_US = `DIO_CYC_PER_US
) (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // two-way pins
  input wire [6:0] pin_in,
  output reg [6:0] pin_out,
  output reg [6:0] pin_oe_n,
  // instrument state and events
  input wire protection_state,
  input wire output_on,
  input wire sync_src,
  input wire ac_step,
  input wire dc_step,
  input wire freq_step,
  input wire seq_trig,
  // derived controls
  output reg output_inhibit_q,
  output reg protection_clear_in,
  output reg sync_in_q,
  output reg first_event_pulse_in,
  output reg second_event_pin_in,
  output reg irq_q
);
  reg [6:0] invert_q;
  reg [13:0] func_q;
  reg [6:0] gpo_q;
  reg [7:0] trig_en_q;
  reg [8:0] pulse_w_q;
  reg [5:0] irq_stat_q;
  reg [5:0] irq_mask_q;
  reg inh_latch_q;
  reg [6:0] sense_q;
  reg [6:0] sense_prev_q;
  reg [6:0] drive_d;
  reg [6:0] oe_n_d;
  reg [31:0] rdata_d;
  reg [5:0] ev_d;
  reg [8:0] pw_d;
  wire [6:0] sense_d;
  wire [1:0] fn [0:6];
  wire [3:0] step_ev;
  wire fire1;
  wire fire2;
  wire pulse1_q;
  wire pulse2_q;
  wire [31:0] width_full;
  wire [15:0] width_cyc;
  wire wr_go;
  wire inh_level;
  integer i;

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_fn
      assign fn[g] = func_q[2*g+1:2*g];
    end
  endgenerate

  assign sense_d = pin_in ^ invert_q;
  assign wr_go = avs_write && !avs_waitrequest;

  // ****************************************
  // trigger conditions and pulse timers
  // ****************************************
  assign step_ev = {seq_trig, freq_step, dc_step, ac_step};
  assign fire1 = (fn[5] == `DIO_FN_SPEC_A) && |(trig_en_q[3:0] & step_ev);
  assign fire2 = (fn[6] == `DIO_FN_SPEC_A) && |(trig_en_q[7:4] & step_ev);
  assign width_full = pulse_w_q * CYC_PER_US;
  assign width_cyc = width_full[15:0];

  dio_pulse u_pulse1 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fire(fire1),
    .width_cyc(width_cyc),
    .active_q(pulse1_q)
  );

  dio_pulse u_pulse2 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fire(fire2),
    .width_cyc(width_cyc),
    .active_q(pulse2_q)
  );

  // ****************************************
  // pin drive selection
  // ****************************************
  always @* begin
    drive_d = gpo_q;
    oe_n_d = 7'h7f;
    for (i = 0; i < 7; i = i + 1) begin
      if (fn[i] == `DIO_FN_OUTPUT) begin
        oe_n_d[i] = 1'b0;
      end
    end
    if (fn[2] == `DIO_FN_SPEC_A) begin
      drive_d[2] = protection_state;
      oe_n_d[2] = 1'b0;
    end
    if (fn[3] == `DIO_FN_SPEC_B) begin
      drive_d[3] = sync_src;
      oe_n_d[3] = 1'b0;
    end
    if (fn[4] == `DIO_FN_SPEC_A) begin
      drive_d[4] = output_on;
      oe_n_d[4] = 1'b0;
    end
    if (fn[5] == `DIO_FN_SPEC_A) begin
      drive_d[5] = pulse1_q;
      oe_n_d[5] = 1'b0;
    end
    if (fn[6] == `DIO_FN_SPEC_A) begin
      drive_d[6] = pulse2_q;
      oe_n_d[6] = 1'b0;
    end
  end

  // ****************************************
  // pin registers and derived controls
  // ****************************************
  // pin 1 inhibit: both spec codes sense; spec b also latches
  assign inh_level = sense_q[0] && (fn[0] == `DIO_FN_SPEC_A || fn[0] == `DIO_FN_SPEC_B);

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out <= 7'h00;
      pin_oe_n <= 7'h7f;
      sense_q <= 7'h00;
      sense_prev_q <= 7'h00;
      inh_latch_q <= 1'b0;
      output_inhibit_q <= 1'b0;
      protection_clear_in <= 1'b0;
      sync_in_q <= 1'b0;
      first_event_pulse_in <= 1'b0;
      second_event_pin_in <= 1'b0;
    end else begin
      pin_out <= drive_d ^ invert_q;
      pin_oe_n <= oe_n_d;
      sense_q <= sense_d;
      sense_prev_q <= sense_q;
      // set wins over the software clear
      if (inh_level && fn[0] == `DIO_FN_SPEC_B) begin
        inh_latch_q <= 1'b1;
      end else if (fn[0] != `DIO_FN_SPEC_B) begin
        inh_latch_q <= 1'b0;
      end else if (wr_go && avs_address == `DIO_REG_CTRL
                   && avs_writedata[`DIO_CTRL_INH_CLR]) begin
        inh_latch_q <= 1'b0;
      end
      output_inhibit_q <= inh_level || inh_latch_q;
      protection_clear_in <= (fn[1] == `DIO_FN_SPEC_A) && sense_q[1] && !sense_prev_q[1];
      sync_in_q <= (fn[3] == `DIO_FN_SPEC_A) && sense_q[3];
      first_event_pulse_in <= (fn[5] == `DIO_FN_SPEC_B) && sense_q[5] && !sense_prev_q[5];
      second_event_pin_in <= (fn[6] == `DIO_FN_SPEC_B) && sense_q[6] && !sense_prev_q[6];
    end
  end

  // ****************************************
  // interrupt events
  // ****************************************
  always @* begin
    ev_d = 6'h00;
    ev_d[`DIO_IRQ_INHIBIT] = !output_inhibit_q && (inh_level || inh_latch_q);
    ev_d[`DIO_IRQ_PCLEAR] = protection_clear_in;
    ev_d[`DIO_IRQ_TRIG1_IN] = first_event_pulse_in;
    ev_d[`DIO_IRQ_SECOND_EVENT_PIN_IN] = second_event_pin_in;
    ev_d[`DIO_IRQ_PULSE1] = fire1 && !pulse1_q;
    ev_d[`DIO_IRQ_PULSE2] = fire2 && !pulse2_q;
  end

  // ****************************************
  // register read mux
  // ****************************************
  always @* begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `DIO_REG_INVERT: rdata_d[6:0] = invert_q;
      `DIO_REG_FUNC: rdata_d[13:0] = func_q;
      `DIO_REG_GPO: rdata_d[6:0] = gpo_q;
      `DIO_REG_GPI: rdata_d[6:0] = sense_q;
      `DIO_REG_TRIG_EN: rdata_d[7:0] = trig_en_q;
      `DIO_REG_PULSE_W: rdata_d[8:0] = pulse_w_q;
      `DIO_REG_IRQ_STAT: rdata_d[5:0] = irq_stat_q;
      `DIO_REG_IRQ_MASK: rdata_d[5:0] = irq_mask_q;
      `DIO_REG_CTRL: rdata_d[1:0] = {pulse2_q | pulse1_q, output_inhibit_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // out-of-range widths are clamped rather than refused
  always @* begin
    pw_d = avs_writedata[8:0];
    if (avs_writedata[31:9] != 23'h000000 || avs_writedata[8:0] > `DIO_PW_MAX_US) begin
      pw_d = `DIO_PW_MAX_US;
    end else if (avs_writedata[8:0] < `DIO_PW_MIN_US) begin
      pw_d = `DIO_PW_MIN_US;
    end
  end

  // ****************************************
  // avalon slave: one wait state per access
  // ****************************************
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      invert_q <= `DIO_RST_INVERT;
      func_q <= `DIO_RST_FUNC;
      gpo_q <= `DIO_RST_GPO;
      trig_en_q <= `DIO_RST_TRIG_EN;
      pulse_w_q <= `DIO_RST_PULSE_W;
      irq_mask_q <= `DIO_RST_IRQ_MASK;
      irq_stat_q <= 6'h00;
      irq_q <= 1'b0;
    end else begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= avs_read ? rdata_d : 32'h00000000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (wr_go) begin
        case (avs_address)
          `DIO_REG_INVERT: invert_q <= avs_writedata[6:0];
          `DIO_REG_FUNC: func_q <= avs_writedata[13:0];
          `DIO_REG_GPO: gpo_q <= avs_writedata[6:0];
          `DIO_REG_TRIG_EN: trig_en_q <= avs_writedata[7:0];
          `DIO_REG_PULSE_W: pulse_w_q <= pw_d;
          `DIO_REG_IRQ_MASK: irq_mask_q <= avs_writedata[5:0];
          default: irq_mask_q <= irq_mask_q;
        endcase
      end
      // write-one-to-clear, a new event in the same cycle wins
      if (wr_go && avs_address == `DIO_REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~avs_writedata[5:0]) | ev_d;
      end else begin
        irq_stat_q <= irq_stat_q | ev_d;
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule

`default_nettype wire

/* File: testbench/dio_pins_sva.sv */
// port checks for the digital i/o block
// assumes bind into dio_pins; config mirrored from bus writes
`include "dio_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dio_pins_sva #(
  parameter CYC_PER_US = `DIO_CYC_PER_US
) (
  // clock, reset, bus
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // pins, events, derived
  input wire logic [6:0] pin_in,
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe_n,
  input wire logic ac_step,
  input wire logic dc_step,
  input wire logic freq_step,
  input wire logic seq_trig,
  input wire logic output_inhibit_q,
  input wire logic protection_clear_in,
  input wire logic sync_in_q
);
  logic [6:0] inv_q;
  logic [13:0] fn_q;
  logic [7:0] en_q;
  logic [28:0] p1_q, p2_q;
  logic [15:0] cnt_q;
  wire logic wr = avs_write && !avs_waitrequest;
  // config must sit still two cycles, outputs lag the write
  wire logic same = {inv_q, fn_q, en_q} == p1_q && p1_q == p2_q;
  wire logic [3:0] ev = {seq_trig, freq_step, dc_step, ac_step};
  wire logic act = pin_out[5] ^ inv_q[5];
  wire logic act2 = pin_out[6] ^ inv_q[6];
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      inv_q <= `DIO_RST_INVERT;
      fn_q <= `DIO_RST_FUNC;
      en_q <= `DIO_RST_TRIG_EN;
      p1_q <= {`DIO_RST_INVERT, `DIO_RST_FUNC, `DIO_RST_TRIG_EN};
      p2_q <= {`DIO_RST_INVERT, `DIO_RST_FUNC, `DIO_RST_TRIG_EN};
      cnt_q <= 16'h0;
    end else begin
      if (wr && avs_address == `DIO_REG_INVERT) inv_q <= avs_writedata[6:0];
      if (wr && avs_address == `DIO_REG_FUNC) fn_q <= avs_writedata[13:0];
      if (wr && avs_address == `DIO_REG_TRIG_EN) en_q <= avs_writedata[7:0];
      p1_q <= {inv_q, fn_q, en_q};
      p2_q <= p1_q;
      cnt_q <= act ? cnt_q + 16'h1 : 16'h0;
    end
  end
  a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait state");
  a_gpo_drive: assert property (wr && avs_address == `DIO_REG_GPO && fn_q[3:2] == `DIO_FN_OUTPUT |-> ##2
    pin_out[1] == ($past(avs_writedata[1], 2) ^ inv_q[1]) && !pin_oe_n[1]) else $error("gpo level");
  a_pin_input: assert property (same && fn_q[3:2] == `DIO_FN_INPUT |-> pin_oe_n[1])
    else $error("input pin driven");
  a_trig_one: assert property (|(ev & en_q[3:0]) && fn_q[11:10] == 2'h0 && same && !act |-> ##2 act)
    else $error("pin 6 pulse missing");
  a_trig_two: assert property (|(ev & en_q[7:4]) && fn_q[13:12] == 2'h0 && same && !act2 |-> ##2 act2)
    else $error("pin 7 pulse missing");
  a_pulse_width: assert property ($fell(act) && same && fn_q[11:10] == 2'h0 |->
    cnt_q >= 30 * CYC_PER_US && cnt_q <= 500 * CYC_PER_US) else $error("pulse width");
  // config must also hold until the check, a function change lands one edge early
  a_inhibit_live: assert property (same && fn_q[1:0] == 2'h0 ##2 same |->
    output_inhibit_q == $past(pin_in[0] ^ inv_q[0], 2)) else $error("inhibit level");
  a_sync_follow: assert property (same && fn_q[7:6] == 2'h0 ##2 same |->
    sync_in_q == $past(pin_in[3] ^ inv_q[3], 2)) else $error("sync input");
  a_clear_pulse: assert property (same && fn_q[3:2] == 2'h0 && $rose(pin_in[1] ^ inv_q[1]) |->
    ##2 protection_clear_in ##1 !protection_clear_in) else $error("clear pulse");
endmodule
`default_nettype wire

/* File: testbench/dio_far_side.sv */
// external equipment on the seven pins
// assumes active-low block enables and active-high equipment enables; pins left floating pull up
`timescale 1ns/1ps
`default_nettype none
module dio_far_side (
  // block side
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe_n,
  // equipment side
  input wire logic [6:0] ext_val,
  input wire logic [6:0] ext_en,
  // wire level
  output logic [6:0] pin_in
);
  // when both ends drive one pin, the block's driver wins
  always_comb
    for (int k = 0; k < 7; k++)
      pin_in[k] = !pin_oe_n[k] ? pin_out[k] : ext_en[k] ? ext_val[k] : 1'b1;
endmodule
`default_nettype wire

/* File: testbench/dio_pins_tb_top.sv */
// bench for the digital i/o block
// assumes CYC_PER_US of 1, so a 30 us pulse lasts 30 cycles
`include "dio_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dio_pins_tb_top;
  logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest, prot, inh, pclr, syn, irq;
  logic tin1, tin2;
  logic [3:0] avs_address, ev;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [6:0] pin_in, pin_out, pin_oe_n, ext_val, ext_en;
  logic [31:0] rst_exp [0:9] = '{32'h0, 32'h2aaa, 32'h0, 32'h7f, 32'h0, 32'h1e, 32'h0, 32'h0,
    32'h0, 32'h0};
  int errors = 0, n_checks = 0, cyc = 0, pc;
  dio_pins #(.CYC_PER_US(1)) DUT (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .protection_state(prot), .output_on(prot),
    .sync_src(prot), .ac_step(ev[0]), .dc_step(ev[1]), .freq_step(ev[2]), .seq_trig(ev[3]),
    .output_inhibit_q(inh), .protection_clear_in(pclr), .sync_in_q(syn),
    .first_event_pulse_in(tin1), .second_event_pin_in(tin2), .irq_q(irq));
  dio_far_side FAR (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits for the answer as long as it takes, the cycle ceiling ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("readdata", e, q);
  endtask
  task automatic settle;
    repeat (3) @(negedge mclk);
  endtask
  task automatic ext(input logic [6:0] v, input logic [6:0] en);
    @(posedge mclk);
    ext_val <= v;
    ext_en <= en;
  endtask
  task automatic pulse(input int j, input int w, input int e5, input int e6);
    int c5, c6;
    c5 = 0;
    c6 = 0;
    @(posedge mclk) ev <= 4'(1 << j);
    @(posedge mclk) ev <= 4'h0;
    repeat (w) begin
      @(negedge mclk);
      c5 += pin_out[5];
      c6 += pin_out[6];
    end
    chk("pin 6 pulse", e5, c5);
    chk("pin 7 pulse", e6, c6);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test;
    end
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata, ev, ext_val, ext_en, prot} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) rdc(4'(i), rst_exp[i]);
    chk("pin_oe_n", 32'h7f, pin_oe_n);
    $display("reset test done");
    bus(1'b1, `DIO_REG_FUNC, 32'h3fff);
    bus(1'b1, `DIO_REG_INVERT, 32'h55);
    bus(1'b1, `DIO_REG_GPO, 32'h0f);
    settle;
    chk("pin_out", 32'h5a, pin_out);
    chk("pin_oe_n", 32'h0, pin_oe_n);
    bus(1'b1, `DIO_REG_FUNC, 32'h2aaa);
    ext(7'h33, 7'h7f);
    settle;
    rdc(`DIO_REG_GPI, 32'h66);
    bus(1'b1, `DIO_REG_INVERT, 32'h0);
    ext(7'h0, 7'h0);
    $display("gpio test done");
    bus(1'b1, `DIO_REG_FUNC, 32'h02aa);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `DIO_REG_TRIG_EN, 32'(1 << i | 1 << (4 + (i + 1) % 4)));
      for (int j = 0; j < 4; j++)
        pulse(j, 40, j == i ? 30 : 0, j == (i + 1) % 4 ? 30 : 0);
    end
    rdc(`DIO_REG_IRQ_STAT, 32'h30);
    chk("irq_q", 32'h0, irq);
    bus(1'b1, `DIO_REG_IRQ_MASK, 32'h10);
    settle;
    chk("irq_q", 32'h1, irq);
    bus(1'b1, `DIO_REG_IRQ_STAT, 32'h30);
    settle;
    chk("irq_q", 32'h0, irq);
    bus(1'b1, `DIO_REG_PULSE_W, 32'h3ff);
    rdc(`DIO_REG_PULSE_W, 32'h1f4);
    pulse(3, 520, 500, 0);
    bus(1'b1, `DIO_REG_PULSE_W, 32'h5);
    rdc(`DIO_REG_PULSE_W, 32'h1e);
    $display("trigger test done");
    prot <= 1'b1;
    bus(1'b1, `DIO_REG_FUNC, 32'h0200);
    ext(7'h00, 7'h0b);
    settle;
    chk("inhibit", 32'h0, inh);
    chk("status pin", 32'h1, pin_out[2]);
    ext(7'h0b, 7'h0b);
    pc = 0;
    repeat (4) begin
      @(negedge mclk);
      pc += pclr;
    end
    chk("clear pulses", 32'h1, pc);
    chk("inhibit", 32'h1, inh);
    chk("sync in", 32'h1, syn);
    bus(1'b1, `DIO_REG_FUNC, 32'h0241);
    ext(7'h00, 7'h0b);
    settle;
    chk("inhibit", 32'h1, inh);
    chk("sync out", 32'h1, pin_out[3]);
    rdc(`DIO_REG_CTRL, 32'h1);
    bus(1'b1, `DIO_REG_CTRL, 32'h1);
    settle;
    chk("inhibit", 32'h0, inh);
    $display("pin function test done");
    // equipment holds pins 6 and 7 low first, so releasing them makes no edge
    ext(7'h00, 7'h6b);
    bus(1'b1, `DIO_REG_FUNC, 32'h16aa);
    settle;
    bus(1'b1, `DIO_REG_IRQ_STAT, 32'h3f);
    ext(7'h60, 7'h6b);
    pc = 0;
    repeat (4) begin
      @(negedge mclk);
      pc += tin1 + tin2;
    end
    chk("trigger in pulses", 32'h2, pc);
    rdc(`DIO_REG_IRQ_STAT, 32'hc);
    $display("trigger input test done");
    finish_test;
  end
endmodule
bind dio_pins dio_pins_sva #(.CYC_PER_US(CYC_PER_US)) u_sva (.mclk(mclk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ac_step(ac_step), .dc_step(dc_step),
  .freq_step(freq_step), .seq_trig(seq_trig), .output_inhibit_q(output_inhibit_q),
  .protection_clear_in(protection_clear_in), .sync_in_q(sync_in_q));
`default_nettype wire
